/* File: rtl/uart_fifo_break_shadow_ctrl.sv */
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
// Notes on behaviour
// - The break shadow and the line control break bit are one flip-flop.
// - While break is set outside loopback the serial output is driven to logic zero.
// - Outside loopback the serial output stays low until break clears.
// - In infrared mode with break set outside loopback the infrared output keeps pulsing.
// - In loopback the break goes to the own receiver, not the pin.
// - The DMA mode shadow mirrors the fifo control DMA bit, mode 0 or 1.
// - The fifo enable shadow mirrors the fifo control enable bit.
// - Clearing fifo enable from one resets both fifo controllers.
// - The trigger shadow writes only the receive trigger field.
// - Code 00 is one character and code 11 is two less than full.
// - Receive data available is raised when the fill reaches the trigger with the fifos enabled, and at one character with them disabled.
// - In DMA mode 1 with the fifos enabled the receive request follows the trigger level.
module uart_fifo_break_shadow_ctrl
	import uart_shadow_pkg::*;
(
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [31:0]        awaddr,
	input  wire logic [2:0]         awprot,
	input  wire logic               awvalid,
	output logic                    awready,
	input  wire logic [31:0]        wdata,
	input  wire logic [3:0]         wstrb,
	input  wire logic               wvalid,
	output logic                    wready,
	output logic [1:0]              bresp,
	output logic                    bvalid,
	input  wire logic               bready,
	input  wire logic [31:0]        araddr,
	input  wire logic [2:0]         arprot,
	input  wire logic               arvalid,
	output logic                    arready,
	output logic [31:0]             rdata,
	output logic [1:0]              rresp,
	output logic                    rvalid,
	input  wire logic               rready,
	input  wire logic               tx_serial_data,
	input  wire logic               rx_serial_pin,
	input  wire logic [LEVEL_W-1:0] rx_fifo_level,
	input  wire logic [LEVEL_W-1:0] tx_fifo_level,
	output logic                    serial_tx_line,
	output logic                    ir_tx_output_low,
	output logic                    rx_loop_data,
	output logic                    tx_fifo_ctrl_reset,
	output logic                    rx_fifo_ctrl_reset,
	output logic                    fifos_enabled,
	output logic                    tx_dma_request_low,
	output logic                    rx_dma_request_low,
	output logic                    irq
);

	function automatic logic [LEVEL_W-1:0] trigger_level
	(
		input logic [1:0] code
	);
		if (code == CODE_ONE)
			trigger_level = TRIG_ONE;
		else if (code == CODE_QUARTER)
			trigger_level = TRIG_QUARTER;
		else if (code == CODE_HALF)
			trigger_level = TRIG_HALF;
		else
			trigger_level = TRIG_NEAR_FULL;
	endfunction : trigger_level

	// pin synchroniser
	logic                rx_sync1;
	logic                rx_sync2;

	// bus state
	wr_state_t           wr_state;
	wr_state_t           next_wr_state;
	rd_state_t           rd_state;
	rd_state_t           next_rd_state;
	logic [31:0]         wr_addr;
	logic [31:0]         next_wr_addr;
	logic [31:0]         wr_data;
	logic [31:0]         next_wr_data;
	logic [3:0]          wr_strb;
	logic [3:0]          next_wr_strb;
	logic [1:0]          next_bresp;
	logic [31:0]         next_rdata;
	logic [1:0]          next_rresp;

	// control state
	logic [7:0]          line_control_word;
	logic [7:0]          next_lcr;
	logic [7:0]          modem_control_word;
	logic [7:0]          next_mcr;
	logic                fifo_enable;
	logic                next_fifo_enable;
	logic                dma_mode;
	logic                next_dma_mode;
	logic [1:0]          rx_trigger;
	logic [1:0]          next_rx_trigger;
	logic [INT_BITS-1:0] int_status;
	logic [INT_BITS-1:0] next_int_status;
	logic [INT_BITS-1:0] int_enable;
	logic [INT_BITS-1:0] next_int_enable;
	logic                next_tx_reset;
	logic                next_rx_reset;
	logic                next_tx_dma_low;
	logic                next_rx_dma_low;
	logic                next_irq;

	// write decode helpers
	logic                wr_fire;
	logic [31:0]         eff_addr;
	logic [31:0]         eff_data;
	logic                eff_low;
	logic                wr_ok;
	logic [INT_BITS-1:0] clear_bits;
	logic [INT_BITS-1:0] events;
	logic [LEVEL_W-1:0]  rx_level_goal;
	logic                rx_avail;

	line_drive_if line ();

	assign line.break_on = line_control_word[LCR_BREAK_BIT];
	assign line.loopback = modem_control_word[MCR_LOOP_BIT];
	assign line.ir_mode  = modem_control_word[MCR_IR_BIT];
	assign line.tx_data  = tx_serial_data;
	assign line.rx_pin   = rx_sync2;

	line_driver u_line_driver
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.line    (line.drv)
	);

	assign serial_tx_line   = line.serial_tx;
	assign ir_tx_output_low = line.ir_tx_low;
	assign rx_loop_data     = line.rx_loop;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_sync1 <= 1'b1;
			rx_sync2 <= 1'b1;
		end
		else
		begin
			rx_sync1 <= rx_serial_pin;
			rx_sync2 <= rx_sync1;
		end
	end

	// write channel: address and data accepted in either order
	always_comb
	begin
		next_wr_state = wr_state;
		next_wr_addr  = wr_addr;
		next_wr_data  = wr_data;
		next_wr_strb  = wr_strb;
		wr_fire       = 1'b0;
		case (wr_state)
			WR_IDLE:
			begin
				// readies stay low for one cycle after reset
				if (awready && awvalid && wvalid)
				begin
					wr_fire       = 1'b1;
					next_wr_state = WR_RESP;
				end
				else if (awready && awvalid)
				begin
					next_wr_addr  = awaddr;
					next_wr_state = WR_ADDR;
				end
				else if (wready && wvalid)
				begin
					next_wr_data  = wdata;
					next_wr_strb  = wstrb;
					next_wr_state = WR_DATA;
				end
			end
			WR_ADDR:
			begin
				if (wvalid)
				begin
					wr_fire       = 1'b1;
					next_wr_state = WR_RESP;
				end
			end
			WR_DATA:
			begin
				if (awvalid)
				begin
					wr_fire       = 1'b1;
					next_wr_state = WR_RESP;
				end
			end
			WR_RESP:
			begin
				if (bready)
					next_wr_state = WR_IDLE;
			end
			default:
				next_wr_state = WR_IDLE;
		endcase
		eff_addr = (wr_state == WR_ADDR) ? wr_addr : awaddr;
		eff_data = (wr_state == WR_DATA) ? wr_data : wdata;
		eff_low  = (wr_state == WR_DATA) ? wr_strb[0] : wstrb[0];
	end

	// register updates; upper bytes are never stored
	always_comb
	begin
		next_lcr         = line_control_word;
		next_mcr         = modem_control_word;
		next_fifo_enable = fifo_enable;
		next_dma_mode    = dma_mode;
		next_rx_trigger  = rx_trigger;
		next_int_enable  = int_enable;
		next_tx_reset    = 1'b0;
		next_rx_reset    = 1'b0;
		clear_bits       = '0;
		wr_ok            = 1'b1;
		if (eff_addr == ADDR_LINE_CTRL)
		begin
			if (wr_fire && eff_low)
				next_lcr = eff_data[7:0];
		end
		else if (eff_addr == ADDR_BREAK_SHADOW)
		begin
			if (wr_fire && eff_low)
				next_lcr[LCR_BREAK_BIT] = eff_data[0];
		end
		else if (eff_addr == ADDR_FIFO_CTRL)
		begin
			if (wr_fire && eff_low)
			begin
				next_fifo_enable = eff_data[FCR_ENABLE_BIT];
				next_dma_mode    = eff_data[FCR_DMA_BIT];
				next_rx_trigger  =
					eff_data[FCR_TRIG_MSB:FCR_TRIG_LSB];
				next_rx_reset    = eff_data[FCR_RX_RST_BIT];
				next_tx_reset    = eff_data[FCR_TX_RST_BIT];
			end
		end
		else if (eff_addr == ADDR_DMA_SHADOW)
		begin
			if (wr_fire && eff_low)
				next_dma_mode = eff_data[0];
		end
		else if (eff_addr == ADDR_FIFO_SHADOW)
		begin
			if (wr_fire && eff_low)
				next_fifo_enable = eff_data[0];
		end
		else if (eff_addr == ADDR_TRIG_SHADOW)
		begin
			if (wr_fire && eff_low)
				next_rx_trigger = eff_data[1:0];
		end
		else if (eff_addr == ADDR_MODEM_CTRL)
		begin
			if (wr_fire && eff_low)
				next_mcr = eff_data[7:0];
		end
		else if (eff_addr == ADDR_INT_CLEAR)
		begin
			if (wr_fire && eff_low)
				clear_bits = eff_data[INT_BITS-1:0];
		end
		else if (eff_addr == ADDR_INT_ENABLE)
		begin
			if (wr_fire && eff_low)
				next_int_enable = eff_data[INT_BITS-1:0];
		end
		else if (eff_addr != ADDR_INT_STATUS)
			wr_ok = 1'b0;
		// a disable clears both controllers, not the data
		if (fifo_enable && !next_fifo_enable)
		begin
			next_rx_reset = 1'b1;
			next_tx_reset = 1'b1;
		end
		next_bresp = bresp;
		if (wr_fire)
			next_bresp = wr_ok ? RESP_OKAY : RESP_DECERR;
	end

	// fill comparison, dma requests and interrupt
	always_comb
	begin
		rx_level_goal = fifo_enable ? trigger_level(rx_trigger) : TRIG_ONE;
		rx_avail      = rx_fifo_level >= rx_level_goal;
		if (fifo_enable && dma_mode)
		begin
			next_rx_dma_low = !rx_avail;
			next_tx_dma_low = !(tx_fifo_level < FIFO_DEPTH);
		end
		else
		begin
			next_rx_dma_low = rx_fifo_level == '0;
			next_tx_dma_low = tx_fifo_level != '0;
		end
		events               = '0;
		events[INT_RX_AVAIL] = rx_avail;
		events[INT_FIFO_RST] = next_rx_reset || next_tx_reset;
		// a new event beats a clear in the same cycle
		next_int_status = (int_status & ~clear_bits) | events;
		next_irq        = |(next_int_status & next_int_enable);
	end

	// read channel
	always_comb
	begin
		next_rd_state = rd_state;
		next_rdata    = rdata;
		next_rresp    = rresp;
		case (rd_state)
			RD_IDLE:
			begin
				if (arvalid && arready)
				begin
					next_rd_state = RD_DATA;
					next_rdata    = 32'h0000_0000;
					next_rresp    = RESP_OKAY;
					if (araddr == ADDR_LINE_CTRL)
						next_rdata[7:0] = line_control_word;
					else if (araddr == ADDR_BREAK_SHADOW)
						next_rdata[0] = line_control_word[LCR_BREAK_BIT];
					else if (araddr == ADDR_FIFO_CTRL)
					begin
						next_rdata[FCR_ENABLE_BIT] = fifo_enable;
						next_rdata[FCR_DMA_BIT]    = dma_mode;
						next_rdata[FCR_TRIG_MSB:FCR_TRIG_LSB] = rx_trigger;
					end
					else if (araddr == ADDR_DMA_SHADOW)
						next_rdata[0] = dma_mode;
					else if (araddr == ADDR_FIFO_SHADOW)
						next_rdata[0] = fifo_enable;
					else if (araddr == ADDR_TRIG_SHADOW)
						next_rdata[1:0] = rx_trigger;
					else if (araddr == ADDR_MODEM_CTRL)
						next_rdata[7:0] = modem_control_word;
					else if (araddr == ADDR_INT_STATUS)
						next_rdata[INT_BITS-1:0] = int_status;
					else if (araddr == ADDR_INT_ENABLE)
						next_rdata[INT_BITS-1:0] = int_enable;
					else if (araddr != ADDR_INT_CLEAR)
						next_rresp = RESP_DECERR;
				end
			end
			RD_DATA:
			begin
				if (rready)
					next_rd_state = RD_IDLE;
			end
			default:
				next_rd_state = RD_IDLE;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_state           <= WR_IDLE;
			rd_state           <= RD_IDLE;
			wr_addr            <= 32'h0000_0000;
			wr_data            <= 32'h0000_0000;
			wr_strb            <= 4'h0;
			awready            <= 1'b0;
			wready             <= 1'b0;
			bvalid             <= 1'b0;
			bresp              <= RESP_OKAY;
			arready            <= 1'b0;
			rvalid             <= 1'b0;
			rdata              <= 32'h0000_0000;
			rresp              <= RESP_OKAY;
			line_control_word                <= LCR_RESET;
			modem_control_word                <= MCR_RESET;
			fifo_enable        <= 1'b0;
			dma_mode           <= 1'b0;
			rx_trigger         <= CODE_ONE;
			int_status         <= '0;
			int_enable         <= '0;
			tx_fifo_ctrl_reset <= 1'b0;
			rx_fifo_ctrl_reset <= 1'b0;
			fifos_enabled      <= 1'b0;
			tx_dma_request_low <= 1'b1;
			rx_dma_request_low <= 1'b1;
			irq                <= 1'b0;
		end
		else
		begin
			wr_state           <= next_wr_state;
			rd_state           <= next_rd_state;
			wr_addr            <= next_wr_addr;
			wr_data            <= next_wr_data;
			wr_strb            <= next_wr_strb;
			awready            <= next_wr_state == WR_IDLE
				|| next_wr_state == WR_DATA;
			wready             <= next_wr_state == WR_IDLE
				|| next_wr_state == WR_ADDR;
			bvalid             <= next_wr_state == WR_RESP;
			bresp              <= next_bresp;
			arready            <= next_rd_state == RD_IDLE;
			rvalid             <= next_rd_state == RD_DATA;
			rdata              <= next_rdata;
			rresp              <= next_rresp;
			line_control_word                <= next_lcr;
			modem_control_word                <= next_mcr;
			fifo_enable        <= next_fifo_enable;
			dma_mode           <= next_dma_mode;
			rx_trigger         <= next_rx_trigger;
			int_status         <= next_int_status;
			int_enable         <= next_int_enable;
			tx_fifo_ctrl_reset <= next_tx_reset;
			rx_fifo_ctrl_reset <= next_rx_reset;
			fifos_enabled      <= next_fifo_enable;
			tx_dma_request_low <= next_tx_dma_low;
			rx_dma_request_low <= next_rx_dma_low;
			irq                <= next_irq;
		end
	end

endmodule : uart_fifo_break_shadow_ctrl

/* File: rtl/uart_shadow_pkg.sv */
package uart_shadow_pkg;

	// register byte addresses on the AXI4-Lite bus
	localparam logic [31:0] ADDR_FIFO_CTRL    = 32'h5000_1108;
	localparam logic [31:0] ADDR_LINE_CTRL    = 32'h5000_110c;
	localparam logic [31:0] ADDR_MODEM_CTRL   = 32'h5000_1110;
	localparam logic [31:0] ADDR_BREAK_SHADOW = 32'h5000_1190;
	localparam logic [31:0] ADDR_DMA_SHADOW   = 32'h5000_1194;
	localparam logic [31:0] ADDR_FIFO_SHADOW  = 32'h5000_1198;
	localparam logic [31:0] ADDR_TRIG_SHADOW  = 32'h5000_119c;
	localparam logic [31:0] ADDR_INT_STATUS   = 32'h5000_11b0;
	localparam logic [31:0] ADDR_INT_CLEAR    = 32'h5000_11b4;
	localparam logic [31:0] ADDR_INT_ENABLE   = 32'h5000_11b8;

	// field positions
	localparam int LCR_BREAK_BIT  = 6;
	localparam int FCR_ENABLE_BIT = 0;
	localparam int FCR_RX_RST_BIT = 1;
	localparam int FCR_TX_RST_BIT = 2;
	localparam int FCR_DMA_BIT    = 3;
	localparam int FCR_TRIG_LSB   = 6;
	localparam int FCR_TRIG_MSB   = 7;
	localparam int MCR_LOOP_BIT   = 4;
	localparam int MCR_IR_BIT     = 6;
	localparam int INT_RX_AVAIL   = 0;
	localparam int INT_FIFO_RST   = 1;
	localparam int INT_BITS       = 2;

	// reset values
	localparam logic [7:0] LCR_RESET = 8'h00;
	localparam logic [7:0] MCR_RESET = 8'h00;

	// fifo depth and receive trigger levels
	localparam int           LEVEL_W        = 5;
	localparam logic [4:0]   FIFO_DEPTH     = 5'h10;
	localparam logic [4:0]   TRIG_ONE       = 5'h01;
	localparam logic [4:0]   TRIG_QUARTER   = 5'h04;
	localparam logic [4:0]   TRIG_HALF      = 5'h08;
	localparam logic [4:0]   TRIG_NEAR_FULL = 5'h0e;
	localparam logic [1:0]   CODE_ONE       = 2'h0;
	localparam logic [1:0]   CODE_QUARTER   = 2'h1;
	localparam logic [1:0]   CODE_HALF      = 2'h2;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// infrared pulse timing
	localparam int         CLK_PERIOD_NS = 100;
	localparam int         IR_PERIOD_NS  = 1600;
	localparam int         IR_PULSE_NS   = 300;
	localparam logic [4:0] IR_LAST_CYC   =
		5'(IR_PERIOD_NS / CLK_PERIOD_NS - 1);
	localparam logic [4:0] IR_PULSE_CYC  =
		5'((IR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef enum logic [1:0]
	{
		WR_IDLE = 2'h0,
		WR_RESP = 2'h1,
		WR_ADDR = 2'h3,
		WR_DATA = 2'h2
	} wr_state_t;

	typedef enum logic
	{
		RD_IDLE = 1'b0,
		RD_DATA = 1'b1
	} rd_state_t;

endpackage : uart_shadow_pkg

/* File: rtl/line_drive_if.sv */
`timescale 1ns/100ps
interface line_drive_if;
	logic break_on;
	logic loopback;
	logic ir_mode;
	logic tx_data;
	logic rx_pin;
	logic serial_tx;
	logic ir_tx_low;
	logic rx_loop;

	modport ctrl
	(
		output break_on, loopback, ir_mode, tx_data, rx_pin,
		input  serial_tx, ir_tx_low, rx_loop
	);
	modport drv
	(
		input  break_on, loopback, ir_mode, tx_data, rx_pin,
		output serial_tx, ir_tx_low, rx_loop
	);
endinterface : line_drive_if

/* File: rtl/line_driver.sv */
`timescale 1ns/100ps
module line_driver
	import uart_shadow_pkg::*;
(
	input wire logic   aclk,
	input wire logic   aresetn,
	line_drive_if.drv  line
);

	logic [4:0] ir_count;
	logic [4:0] next_ir_count;
	logic       serial_tx;
	logic       next_serial_tx;
	logic       ir_tx_low;
	logic       next_ir_tx_low;
	logic       rx_loop;
	logic       next_rx_loop;
	logic       space_bit;
	logic       ir_active;

	always_comb
	begin
		space_bit = line.break_on || !line.tx_data;
		// sir pulses while spacing; a break keeps it pulsing
		ir_active = line.ir_mode && !line.loopback && space_bit;
		next_ir_count = 5'h00;
		if (ir_active && ir_count != IR_LAST_CYC)
			next_ir_count = ir_count + 5'h01;
		next_ir_tx_low = !(ir_active && ir_count < IR_PULSE_CYC);
		// in loopback the line idles at mark, break goes inward
		if (line.loopback)
			next_serial_tx = 1'b1;
		else if (line.break_on)
			next_serial_tx = 1'b0;
		else
			next_serial_tx = line.tx_data;
		if (line.loopback)
			next_rx_loop = line.break_on ? 1'b0 : line.tx_data;
		else
			next_rx_loop = line.rx_pin;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ir_count  <= 5'h00;
			serial_tx <= 1'b1;
			ir_tx_low <= 1'b1;
			rx_loop   <= 1'b1;
		end
		else
		begin
			ir_count  <= next_ir_count;
			serial_tx <= next_serial_tx;
			ir_tx_low <= next_ir_tx_low;
			rx_loop   <= next_rx_loop;
		end
	end

	assign line.serial_tx = serial_tx;
	assign line.ir_tx_low = ir_tx_low;
	assign line.rx_loop   = rx_loop;

endmodule : line_driver

/* File: dv/uart_fifo_break_shadow_ctrl_asserts.sv */
`timescale 1ns/100ps
module shadow_ctrl_asserts
	import uart_shadow_pkg::*;
(
	input wire logic               aclk,
	input wire logic               aresetn,
	input wire logic               awvalid,
	input wire logic               awready,
	input wire logic               wvalid,
	input wire logic               wready,
	input wire logic [1:0]         bresp,
	input wire logic               bvalid,
	input wire logic               bready,
	input wire logic               arvalid,
	input wire logic               arready,
	input wire logic [31:0]        rdata,
	input wire logic [1:0]         rresp,
	input wire logic               rvalid,
	input wire logic               rready,
	input wire logic [LEVEL_W-1:0] rx_fifo_level,
	input wire logic [LEVEL_W-1:0] tx_fifo_level,
	input wire logic               tx_dma_request_low,
	input wire logic               rx_dma_request_low,
	input wire logic               fifos_enabled,
	input wire logic               tx_fifo_ctrl_reset,
	input wire logic               rx_fifo_ctrl_reset
);
	logic both_rst;

	assign both_rst = tx_fifo_ctrl_reset && rx_fifo_ctrl_reset;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_wr_take;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_rd_take;
		arvalid && arready;
	endsequence
	// two quiet samples so a level change in flight cannot trip it
	sequence s_rx_empty;
		(rx_fifo_level == 5'h00) [*2];
	endsequence

	property p_wr_answer;
		s_wr_take |=> bvalid && !awready && !wready;
	endproperty
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	property p_b_done;
		bvalid && bready |=> !bvalid ##[0:1] (awready && wready);
	endproperty
	property p_rd_answer;
		s_rd_take |=> rvalid && !arready;
	endproperty
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
	endproperty
	property p_r_done;
		rvalid && rready |=> !rvalid ##[0:1] arready;
	endproperty
	// pulse may lead or trail the enable output by a cycle
	property p_fifo_off;
		$fell(fifos_enabled) |-> ##[0:1] (both_rst || $past(both_rst));
	endproperty
	property p_rx_idle;
		s_rx_empty |=> rx_dma_request_low;
	endproperty
	property p_tx_empty;
		(tx_fifo_level == 5'h00) [*2] |=> !tx_dma_request_low;
	endproperty

	a_wr_answer: assert property (p_wr_answer)
		else $error("write response not one cycle after take");
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped before bready");
	a_b_done: assert property (p_b_done)
		else $error("write channel not idle after response");
	a_rd_answer: assert property (p_rd_answer)
		else $error("read data not one cycle after take");
	a_r_hold: assert property (p_r_hold)
		else $error("read data changed before rready");
	a_r_done: assert property (p_r_done)
		else $error("read channel not idle after response");
	a_fifo_off: assert property (p_fifo_off)
		else $error("fifo disable without controller reset");
	a_rx_idle: assert property (p_rx_idle)
		else $error("receive request with empty fifo");
	a_tx_empty: assert property (p_tx_empty)
		else $error("no transmit request with empty fifo");
endmodule : shadow_ctrl_asserts

bind uart_fifo_break_shadow_ctrl shadow_ctrl_asserts chk
(
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready),
	.bresp(bresp), .bvalid(bvalid), .bready(bready),
	.arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rresp(rresp), .rvalid(rvalid), .rready(rready),
	.rx_fifo_level(rx_fifo_level), .tx_fifo_level(tx_fifo_level),
	.tx_dma_request_low(tx_dma_request_low),
	.rx_dma_request_low(rx_dma_request_low),
	.fifos_enabled(fifos_enabled),
	.tx_fifo_ctrl_reset(tx_fifo_ctrl_reset),
	.rx_fifo_ctrl_reset(rx_fifo_ctrl_reset)
);

/* File: dv/remote_serial_dev.sv */
`timescale 1ns/100ps
module remote_serial_dev
(
	input  wire logic  aclk,
	input  wire logic  line_in,
	input  wire logic  send_break,
	output logic       line_out,
	output logic [7:0] low_run
);
	// driven line, idles at mark; a break from here is a held space
	assign line_out = send_break ? 1'b0 : 1'b1;

	// saturating run of space cycles, so a long break stays measurable
	always @(posedge aclk)
	begin
		if (line_in !== 1'b0)
			low_run <= 8'h00;
		else if (low_run != 8'hff)
			low_run <= low_run + 8'h01;
	end
endmodule : remote_serial_dev

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top
	import uart_shadow_pkg::*;
;
	logic               aclk, aresetn, awvalid, awready, wvalid, wready;
	logic               bvalid, bready, arvalid, arready, rvalid, rready;
	logic               tx_serial_data, rx_serial_pin, serial_tx_line;
	logic               ir_tx_output_low, rx_loop_data, fifos_enabled;
	logic               tx_fifo_ctrl_reset, rx_fifo_ctrl_reset, irq;
	logic               tx_dma_request_low, rx_dma_request_low, far_break;
	logic [1:0]         bresp, rresp;
	logic [31:0]        awaddr, wdata, araddr, rdata;
	logic [LEVEL_W-1:0] rx_fifo_level, tx_fifo_level;
	logic [7:0]         low_run;
	logic [4:0]         goals [4];
	logic [31:0]        regs [7];
	int                 fail_count, comparisons, rst_pulses, n;

	uart_fifo_break_shadow_ctrl dut
	(
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.tx_serial_data(tx_serial_data), .rx_serial_pin(rx_serial_pin),
		.rx_fifo_level(rx_fifo_level), .tx_fifo_level(tx_fifo_level),
		.serial_tx_line(serial_tx_line), .irq(irq),
		.ir_tx_output_low(ir_tx_output_low), .rx_loop_data(rx_loop_data),
		.tx_fifo_ctrl_reset(tx_fifo_ctrl_reset),
		.rx_fifo_ctrl_reset(rx_fifo_ctrl_reset),
		.fifos_enabled(fifos_enabled),
		.tx_dma_request_low(tx_dma_request_low),
		.rx_dma_request_low(rx_dma_request_low)
	);

	remote_serial_dev far_end
	(
		.aclk(aclk), .line_in(serial_tx_line), .send_break(far_break),
		.line_out(rx_serial_pin), .low_run(low_run)
	);

	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	always @(posedge aclk)
		if (tx_fifo_ctrl_reset === 1'b1 && rx_fifo_ctrl_reset === 1'b1)
			rst_pulses++;

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// responses are accepted late on purpose, so the slave must hold them
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
		input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		repeat (40)
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
			if (bvalid) bready <= 1'b1;
		end
		check("b_done", 32'(bvalid && bready), 32'h1);
		check("bresp", 32'(bresp), 32'(er));
		bready <= 1'b0;
		@(posedge aclk);
	endtask : axi_wr

	task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		repeat (40)
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
			if (rvalid) rready <= 1'b1;
		end
		check("r_done", 32'(rvalid && rready), 32'h1);
		check("rdata", rdata, ed);
		check("rresp", 32'(rresp), 32'(er));
		rready <= 1'b0;
		@(posedge aclk);
	endtask : axi_rd

	task automatic close_out;
		if (fail_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out

	initial
	begin
		repeat (4000) @(posedge aclk);
		fail_count++;
		close_out();
	end

	initial
	begin
		fail_count = 0;
		comparisons = 0;
		rst_pulses = 0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, wdata, araddr} = 96'h0;
		tx_serial_data = 1'b1;
		far_break = 1'b0;
		rx_fifo_level = 5'h00;
		tx_fifo_level = 5'h00;
		goals = '{TRIG_ONE, TRIG_QUARTER, TRIG_HALF, TRIG_NEAR_FULL};
		regs = '{ADDR_BREAK_SHADOW, ADDR_DMA_SHADOW, ADDR_FIFO_SHADOW,
			ADDR_TRIG_SHADOW, ADDR_FIFO_CTRL, ADDR_LINE_CTRL, ADDR_MODEM_CTRL};
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (regs[i])
			axi_rd(regs[i], 32'h0, RESP_OKAY);
		axi_wr(ADDR_BREAK_SHADOW, 32'hffff_fffe, RESP_OKAY);
		axi_rd(ADDR_LINE_CTRL, 32'h0, RESP_OKAY);
		axi_rd(32'h5000_1000, 32'h0, RESP_DECERR);
		axi_wr(32'h5000_1000, 32'h1, RESP_DECERR);
		axi_wr(ADDR_BREAK_SHADOW, 32'h1, RESP_OKAY);
		axi_rd(ADDR_LINE_CTRL, 32'h40, RESP_OKAY);
		repeat (20) @(posedge aclk);
		check("tx_line", 32'(serial_tx_line), 32'h0);
		check("low_run", 32'(low_run >= 8'h14), 32'h1);
		axi_wr(ADDR_MODEM_CTRL, 32'h40, RESP_OKAY);
		// 32 cycles span two whole pulse periods whatever the phase
		n = 0;
		repeat (32)
		begin
			@(posedge aclk);
			if (ir_tx_output_low === 1'b0) n++;
		end
		check("ir_low", 32'(n), 32'h6);
		axi_wr(ADDR_MODEM_CTRL, 32'h10, RESP_OKAY);
		repeat (2) @(posedge aclk);
		check("tx_line_loop", 32'(serial_tx_line), 32'h1);
		check("rx_loop", 32'(rx_loop_data), 32'h0);
		axi_wr(ADDR_MODEM_CTRL, 32'h0, RESP_OKAY);
		axi_wr(ADDR_LINE_CTRL, 32'h0, RESP_OKAY);
		axi_rd(ADDR_BREAK_SHADOW, 32'h0, RESP_OKAY);
		check("tx_line_idle", 32'(serial_tx_line), 32'h1);
		far_break <= 1'b1;
		repeat (5) @(posedge aclk);
		check("rx_pin", 32'(rx_loop_data), 32'h0);
		far_break <= 1'b0;
		axi_wr(ADDR_DMA_SHADOW, 32'h1, RESP_OKAY);
		axi_rd(ADDR_FIFO_CTRL, 32'h08, RESP_OKAY);
		axi_wr(ADDR_FIFO_SHADOW, 32'h1, RESP_OKAY);
		axi_rd(ADDR_FIFO_CTRL, 32'h09, RESP_OKAY);
		check("fifo_en", 32'(fifos_enabled), 32'h1);
		tx_fifo_level <= FIFO_DEPTH;
		repeat (2) @(posedge aclk);
		check("tx_req_full", 32'(tx_dma_request_low), 32'h1);
		tx_fifo_level <= 5'h00;
		repeat (2) @(posedge aclk);
		check("tx_req_empty", 32'(tx_dma_request_low), 32'h0);
		axi_wr(ADDR_TRIG_SHADOW, 32'hffff_ffff, RESP_OKAY);
		axi_rd(ADDR_TRIG_SHADOW, 32'h3, RESP_OKAY);
		axi_rd(ADDR_FIFO_CTRL, 32'hc9, RESP_OKAY);
		axi_wr(ADDR_INT_ENABLE, 32'h1, RESP_OKAY);
		for (int c = 0; c < 4; c++)
		begin
			axi_wr(ADDR_TRIG_SHADOW, 32'(c), RESP_OKAY);
			rx_fifo_level <= goals[c] - 5'h01;
			repeat (5) @(posedge aclk);
			axi_wr(ADDR_INT_CLEAR, 32'h1, RESP_OKAY);
			check("irq_below", 32'(irq), 32'h0);
			check("rx_req_below", 32'(rx_dma_request_low), 32'h1);
			rx_fifo_level <= goals[c];
			repeat (5) @(posedge aclk);
			check("irq_at", 32'(irq), 32'h1);
			check("rx_req_at", 32'(rx_dma_request_low), 32'h0);
		end
		rx_fifo_level <= 5'h00;
		repeat (3) @(posedge aclk);
		axi_wr(ADDR_INT_ENABLE, 32'h2, RESP_OKAY);
		axi_wr(ADDR_INT_CLEAR, 32'h3, RESP_OKAY);
		rst_pulses = 0;
		// second disable must not pulse again
		axi_wr(ADDR_FIFO_SHADOW, 32'h0, RESP_OKAY);
		axi_wr(ADDR_FIFO_SHADOW, 32'h0, RESP_OKAY);
		check("rst_pulses", 32'(rst_pulses), 32'h1);
		check("irq_rst", 32'(irq), 32'h1);
		axi_rd(ADDR_INT_STATUS, 32'h2, RESP_OKAY);
		axi_wr(ADDR_INT_CLEAR, 32'h2, RESP_OKAY);
		axi_rd(ADDR_INT_STATUS, 32'h0, RESP_OKAY);
		close_out();
	end
endmodule : tb_top
